// ==== shared/amt_pkg.sv ====
package amt_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_SUMMARY  = 10'h2c0;
  localparam logic [9:0] IDX_STATUS   = 10'h2c1;
  localparam logic [9:0] IDX_MASK     = 10'h2c2;
  localparam logic [9:0] IDX_LANE     = 10'h2c4;
  localparam logic [9:0] IDX_CTRL     = 10'h2c6;
  localparam logic [9:0] IDX_TRIM_AD  = 10'h310;
  localparam logic [9:0] IDX_TRIM_BD  = 10'h313;
  localparam logic [9:0] IDX_TRIM_ASA = 10'h314;
  localparam logic [9:0] IDX_TRIM_BSA = 10'h315;

  // widths
  localparam int ALM_W  = 6;
  localparam int LANE_W = 16;
  localparam int TRIM_W = 8;

  // alarm bit positions, shared by status and mask
  localparam int BIT_FIFO  = 5;
  localparam int BIT_PLL   = 4;
  localparam int BIT_LINK  = 3;
  localparam int BIT_REALN = 2;
  localparam int BIT_NCO   = 1;
  localparam int BIT_CLK   = 0;

  // control register fields
  localparam int CTRL_DUAL   = 0;
  localparam int CTRL_FGCAL  = 1;
  localparam int CTRL_IN_B   = 2;
  localparam int CTRL_PINSEL = 3;
  localparam int CTRL_W      = 4;

  // values after reset
  localparam logic [ALM_W-1:0]  RST_MASK   = 6'h3f;
  localparam logic [ALM_W-1:0]  RST_STATUS = 6'h3f;
  localparam logic [LANE_W-1:0] RST_LANE   = 16'hffff;
  localparam logic [TRIM_W-1:0] RST_TRIM   = 8'h00;
  localparam logic [CTRL_W-1:0] RST_CTRL   = 4'h1;
endpackage : amt_pkg

// ==== design/amt_regs.sv ====
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
// Summary of operation
// - six mask bits gate alarms from summary
// - mask resets to 0x3f, bits 7:6 zero
// - lane flag i sets on lane i error
// - writing one clears that lane flag
// - persisting lane error sets flag again
// - one to fifo status bit clears lanes
// - lane flags reset to all ones
// - eight-bit trim shifts core sampling moment
// - trims load factory value, software rewrites
// - core A dual mode uses first trim
// - core B dual with calibration, second trim
// - core A single on input A trim
// - core B single on input A trim
// - summary is one for unmasked set status
// - status resets to ones, one clears
// - summary can drive calibration status pin
module amt_regs (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // alarm sources, same clock
  input  wire logic [5:0]  alarm_event,
  input  wire logic [15:0] lane_fifo_err,
  // factory trim values, same clock
  input  wire logic [7:0]  fuse_trim_a_dual,
  input  wire logic [7:0]  fuse_trim_b_dual,
  input  wire logic [7:0]  fuse_trim_a_single,
  input  wire logic [7:0]  fuse_trim_b_single,
  // applied trims to converter cores
  output logic      [7:0]  core_a_trim,
  output logic             core_a_trim_valid,
  output logic      [7:0]  core_b_trim,
  output logic             core_b_trim_valid,
  // calibration status pin
  input  wire logic        cal_status_in,
  output logic             calibration_status_pin
);

  ////////////////////////////////////////////////////////////////////////
  // state
  logic [amt_pkg::ALM_W-1:0]  alarm_source_mask_q;     // gates summary
  logic [amt_pkg::ALM_W-1:0]  alarm_status_register_q; // sticky alarms
  logic [amt_pkg::LANE_W-1:0] lane_fifo_alarm_flags_q; // sticky lanes
  logic [amt_pkg::CTRL_W-1:0] ctrl_q;                  // mode and pin select
  logic [amt_pkg::TRIM_W-1:0] trim_ad_q;               // core A dual
  logic [amt_pkg::TRIM_W-1:0] trim_bd_q;               // core B dual
  logic [amt_pkg::TRIM_W-1:0] trim_asa_q;              // core A single, in A
  logic [amt_pkg::TRIM_W-1:0] trim_bsa_q;              // core B single, in A
  logic                       fuse_load_q;             // fuse copy pending
  logic                       summary_q;               // summary alarm
  logic [31:0]                prdata_q;
  logic                       pready_q;
  logic                       pslverr_q;
  logic [7:0]                 trim_a_q;
  logic [7:0]                 trim_b_q;
  logic                       trim_a_vld_q;
  logic                       trim_b_vld_q;
  logic                       pin_q;

  // decode
  logic [9:0]                 idx;       // word index
  logic                       hit;       // mapped address
  logic                       wr_en;     // write takes effect now
  logic [amt_pkg::ALM_W-1:0]  status_clr;
  logic [amt_pkg::ALM_W-1:0]  status_set;
  logic [amt_pkg::LANE_W-1:0] lane_clr;
  logic [amt_pkg::ALM_W-1:0]  status_d;
  logic [amt_pkg::LANE_W-1:0] lane_d;
  logic [31:0]                rdata_d;

  assign idx = paddr[11:2];

  ////////////////////////////////////////////////////////////////////////
  // address decode and write strobes
  always_comb begin
    unique case (idx)
      amt_pkg::IDX_SUMMARY, amt_pkg::IDX_STATUS, amt_pkg::IDX_MASK,
      amt_pkg::IDX_LANE, amt_pkg::IDX_CTRL, amt_pkg::IDX_TRIM_AD,
      amt_pkg::IDX_TRIM_BD, amt_pkg::IDX_TRIM_ASA,
      amt_pkg::IDX_TRIM_BSA: hit = (paddr[1:0] == 2'h0);
      default:               hit = 1'b0;
    endcase
  end

  // writes act only at the access edge where pready is sampled high
  assign wr_en = psel & penable & pready_q & pwrite & hit;

  // write-one-to-clear terms
  always_comb begin
    status_clr = '0;
    lane_clr   = '0;
    if (wr_en && idx == amt_pkg::IDX_STATUS) begin
      status_clr = pwdata[amt_pkg::ALM_W-1:0];
      if (pwdata[amt_pkg::BIT_FIFO]) begin
        lane_clr = '1;
      end
    end
    if (wr_en && idx == amt_pkg::IDX_LANE) begin
      lane_clr = lane_clr | pwdata[amt_pkg::LANE_W-1:0];
    end
  end

  // an event in the clearing cycle wins, so no alarm is ever lost
  always_comb begin
    status_set = alarm_event;
    status_set[amt_pkg::BIT_FIFO] = alarm_event[amt_pkg::BIT_FIFO] | (|lane_fifo_err);
    status_d = (alarm_status_register_q & ~status_clr) | status_set;
    lane_d   = (lane_fifo_alarm_flags_q & ~lane_clr) | lane_fifo_err;
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky alarm status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_status_register_q <= amt_pkg::RST_STATUS;
    end else begin
      alarm_status_register_q <= status_d;
    end
  end

  // per-lane fifo flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lane_fifo_alarm_flags_q <= amt_pkg::RST_LANE;
    end else begin
      lane_fifo_alarm_flags_q <= lane_d;
    end
  end

  // mask register; reserved bits are not stored and read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alarm_source_mask_q <= amt_pkg::RST_MASK;
    end else if (wr_en && idx == amt_pkg::IDX_MASK) begin
      alarm_source_mask_q <= pwdata[amt_pkg::ALM_W-1:0];
    end
  end

  // mode and pin-select control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= amt_pkg::RST_CTRL;
    end else if (wr_en && idx == amt_pkg::IDX_CTRL) begin
      ctrl_q <= pwdata[amt_pkg::CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // trims: fuse copy taken one edge after reset release, since an async
  // reset may only load constants
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_load_q <= 1'b1;
    end else begin
      fuse_load_q <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_ad_q  <= amt_pkg::RST_TRIM;
      trim_bd_q  <= amt_pkg::RST_TRIM;
      trim_asa_q <= amt_pkg::RST_TRIM;
      trim_bsa_q <= amt_pkg::RST_TRIM;
    end else if (fuse_load_q) begin
      trim_ad_q  <= fuse_trim_a_dual;
      trim_bd_q  <= fuse_trim_b_dual;
      trim_asa_q <= fuse_trim_a_single;
      trim_bsa_q <= fuse_trim_b_single;
    end else if (wr_en) begin
      // software overwrites any factory value
      if (idx == amt_pkg::IDX_TRIM_AD)  trim_ad_q  <= pwdata[7:0];
      if (idx == amt_pkg::IDX_TRIM_BD)  trim_bd_q  <= pwdata[7:0];
      if (idx == amt_pkg::IDX_TRIM_ASA) trim_asa_q <= pwdata[7:0];
      if (idx == amt_pkg::IDX_TRIM_BSA) trim_bsa_q <= pwdata[7:0];
    end
  end

  // trim routing by mode; single mode on input B is served elsewhere,
  // so valid drops and the core keeps its own setting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_a_q     <= amt_pkg::RST_TRIM;
      trim_b_q     <= amt_pkg::RST_TRIM;
      trim_a_vld_q <= 1'b0;
      trim_b_vld_q <= 1'b0;
    end else if (ctrl_q[amt_pkg::CTRL_DUAL]) begin
      trim_a_q     <= trim_ad_q;
      trim_a_vld_q <= 1'b1;
      trim_b_q     <= trim_bd_q;
      trim_b_vld_q <= ctrl_q[amt_pkg::CTRL_FGCAL];
    end else begin
      trim_a_q     <= trim_asa_q;
      trim_b_q     <= trim_bsa_q;
      trim_a_vld_q <= ~ctrl_q[amt_pkg::CTRL_IN_B];
      trim_b_vld_q <= ~ctrl_q[amt_pkg::CTRL_IN_B];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // summary alarm and its pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      summary_q <= 1'b0;
      pin_q     <= 1'b0;
    end else begin
      summary_q <= |(alarm_status_register_q & ~alarm_source_mask_q);
      pin_q     <= ctrl_q[amt_pkg::CTRL_PINSEL] ? summary_q : cal_status_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (idx)
      amt_pkg::IDX_SUMMARY:  rdata_d[0]   = summary_q;
      amt_pkg::IDX_STATUS:   rdata_d[5:0] = alarm_status_register_q;
      amt_pkg::IDX_MASK:     rdata_d[5:0] = alarm_source_mask_q;
      amt_pkg::IDX_LANE:     rdata_d[15:0] = lane_fifo_alarm_flags_q;
      amt_pkg::IDX_CTRL:     rdata_d[3:0] = ctrl_q;
      amt_pkg::IDX_TRIM_AD:  rdata_d[7:0] = trim_ad_q;
      amt_pkg::IDX_TRIM_BD:  rdata_d[7:0] = trim_bd_q;
      amt_pkg::IDX_TRIM_ASA: rdata_d[7:0] = trim_asa_q;
      amt_pkg::IDX_TRIM_BSA: rdata_d[7:0] = trim_bsa_q;
      default:               rdata_d = 32'h0000_0000;
    endcase
  end

  // one wait-free access phase: answer is prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      if (psel && !penable) begin
        prdata_q <= (!pwrite && hit) ? rdata_d : 32'h0000_0000;
      end
    end
  end

  assign prdata                 = prdata_q;
  assign pready                 = pready_q;
  assign pslverr                = pslverr_q;
  assign core_a_trim            = trim_a_q;
  assign core_a_trim_valid      = trim_a_vld_q;
  assign core_b_trim            = trim_b_q;
  assign core_b_trim_valid      = trim_b_vld_q;
  assign calibration_status_pin = pin_q;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_summary_mask: assert property (
    ##1 (summary_q == |($past(alarm_status_register_q) & ~$past(alarm_source_mask_q))))
    else $error("summary does not follow masked status");

  chk_mask_write: assert property (
    (wr_en && idx == amt_pkg::IDX_MASK) |=> (alarm_source_mask_q == $past(pwdata[5:0])))
    else $error("mask write lost");

  chk_lane_set: assert property (
    (|lane_fifo_err) |=> ((lane_fifo_alarm_flags_q & $past(lane_fifo_err)) == $past(lane_fifo_err)))
    else $error("lane error not latched");

  chk_lane_clear: assert property (
    (wr_en && idx == amt_pkg::IDX_LANE && pwdata[0] && !lane_fifo_err[0])
    |=> !lane_fifo_alarm_flags_q[0])
    else $error("lane flag not cleared");

  chk_lane_persist: assert property (
    (lane_clr[7] && lane_fifo_err[7]) |=> lane_fifo_alarm_flags_q[7])
    else $error("persisting lane error lost");

  chk_fifo_all_clear: assert property (
    (wr_en && idx == amt_pkg::IDX_STATUS && pwdata[5] && lane_fifo_err == 16'h0000)
    |=> (lane_fifo_alarm_flags_q == 16'h0000))
    else $error("fifo status write did not clear lanes");

  // presetn in an antecedent is its sampled value: the edge that releases
  // reset still ran the reset branch, so it must not start a check
  chk_fuse_load: assert property (
    (presetn && fuse_load_q)
    |=> (trim_ad_q == $past(fuse_trim_a_dual) && trim_bsa_q == $past(fuse_trim_b_single)))
    else $error("factory trim not loaded");

  chk_dual_route: assert property (
    (presetn && ctrl_q[0] && $stable(ctrl_q))
    |=> (core_a_trim == $past(trim_ad_q) && core_a_trim_valid))
    else $error("dual core A trim misrouted");

  chk_single_route: assert property (
    (!ctrl_q[0] && !ctrl_q[2]) |=> (core_b_trim == $past(trim_bsa_q) && core_b_trim_valid))
    else $error("single core B trim misrouted");

  chk_status_latch: assert property (
    (|alarm_event) |=> ((alarm_status_register_q & $past(alarm_event)) == $past(alarm_event)))
    else $error("status event lost");

  chk_pin_route: assert property (
    (ctrl_q[3] && $stable(ctrl_q)) |=> (calibration_status_pin == $past(summary_q)))
    else $error("pin not showing summary");

endmodule // amt_regs

// ==== dv/tb.sv ====
`timescale 1ns/100ps
module tb;
  ////////////////////////////////////////////////////////////////////////
  // apb side, alarm sources and core outputs
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic [5:0]  alarm_event;
  logic [15:0] lane_fifo_err;
  logic [7:0]  core_a_trim, core_b_trim;
  logic        core_a_trim_valid, core_b_trim_valid, cal_status_in, calibration_status_pin;
  int          num_errors, n_compared;
  // factory values kept distinct so a swapped route shows up
  localparam logic [7:0] F_AD = 8'h5a, F_BD = 8'h6b, F_ASA = 8'h7c, F_BSA = 8'h8d;
  // one row: write or read-and-compare
  typedef struct packed { logic w; logic [9:0] idx; logic [31:0] d; } amt_row_s;
  amt_row_s    rows [23];
  logic [3:0]  md [4];
  logic [17:0] ex [4];

  amt_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .alarm_event(alarm_event), .lane_fifo_err(lane_fifo_err), .fuse_trim_a_dual(F_AD),
    .fuse_trim_b_dual(F_BD), .fuse_trim_a_single(F_ASA), .fuse_trim_b_single(F_BSA),
    .core_a_trim(core_a_trim), .core_a_trim_valid(core_a_trim_valid), .core_b_trim(core_b_trim),
    .core_b_trim_valid(core_b_trim_valid), .cal_status_in(cal_status_in),
    .calibration_status_pin(calibration_status_pin));

  ////////////////////////////////////////////////////////////////////////
  // 250 MHz clock
  always #2 pclk = ~pclk;

  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer; entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    // the slave answers in the first access cycle, no wait states
    chk("access cycles", n, 32'h1);
    v  = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle cycle keeps the next setup off this edge
    @(posedge pclk);
  endtask

  task automatic wr(input logic [9:0] i, input logic [31:0] d);
    apb(1'b1, {i, 2'b00}, d);
  endtask

  task automatic rd(input logic [9:0] i);
    apb(1'b0, {i, 2'b00}, 32'h0);
  endtask

  task automatic final_report;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // watchdog: the whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    num_errors++;
    final_report;
  end

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    alarm_event = 0; lane_fifo_err = 0; cal_status_in = 0; num_errors = 0; n_compared = 0;
    rows = '{
      '{0, amt_pkg::IDX_MASK, 32'h3f}, '{0, amt_pkg::IDX_LANE, 32'hffff},
      '{0, amt_pkg::IDX_STATUS, 32'h3f}, '{0, amt_pkg::IDX_SUMMARY, 32'h0},
      '{0, amt_pkg::IDX_TRIM_AD, {24'h0, F_AD}}, '{0, amt_pkg::IDX_TRIM_BD, {24'h0, F_BD}},
      '{0, amt_pkg::IDX_TRIM_ASA, {24'h0, F_ASA}}, '{0, amt_pkg::IDX_TRIM_BSA, {24'h0, F_BSA}},
      '{1, amt_pkg::IDX_MASK, 32'hffffffc0}, '{0, amt_pkg::IDX_MASK, 32'h0},
      '{1, amt_pkg::IDX_LANE, 32'h0001}, '{0, amt_pkg::IDX_LANE, 32'hfffe},
      '{1, amt_pkg::IDX_STATUS, 32'h20}, '{0, amt_pkg::IDX_LANE, 32'h0},
      '{0, amt_pkg::IDX_STATUS, 32'h1f}, '{1, amt_pkg::IDX_STATUS, 32'h1f},
      '{0, amt_pkg::IDX_STATUS, 32'h0}, '{1, amt_pkg::IDX_TRIM_AD, 32'ha1},
      '{1, amt_pkg::IDX_TRIM_BD, 32'hb2}, '{1, amt_pkg::IDX_TRIM_ASA, 32'hc3},
      '{1, amt_pkg::IDX_TRIM_BSA, 32'hd4}, '{0, amt_pkg::IDX_TRIM_AD, 32'ha1},
      '{0, amt_pkg::IDX_TRIM_BSA, 32'hd4}};
    // mode per row: dual, dual with calibration, single on a, single on b
    md = '{4'h1, 4'h3, 4'h0, 4'h4};
    ex = '{{1'b1, 8'ha1, 1'b0, 8'h0}, {1'b1, 8'ha1, 1'b1, 8'hb2}, {1'b1, 8'hc3, 1'b1, 8'hd4}, 18'h0};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].idx, rows[i].d);
      else begin
        rd(rows[i].idx);
        chk($sformatf("row %0d", i), v, rows[i].d);
      end
      chk("row err", {31'h0, er}, 32'h0);
    end
    // lane event latches although every source is masked
    wr(amt_pkg::IDX_MASK, 32'h3f);
    lane_fifo_err <= 16'h0008;
    @(posedge pclk);
    lane_fifo_err <= 16'h0;
    rd(amt_pkg::IDX_LANE);
    chk("lane flags", v, 32'h0008);
    rd(amt_pkg::IDX_STATUS);
    chk("status latched", v, 32'h20);
    rd(amt_pkg::IDX_SUMMARY);
    chk("summary all masked", v, 32'h0);
    // a persisting error sets its flag again at once
    lane_fifo_err <= 16'h0080;
    wr(amt_pkg::IDX_LANE, 32'h0088);
    rd(amt_pkg::IDX_LANE);
    chk("lane re-armed", v, 32'h0080);
    lane_fifo_err <= 16'h0;
    wr(amt_pkg::IDX_STATUS, 32'h3f);
    // each source reaches the summary only when its gate is open
    for (int b = 0; b < 6; b++) begin
      wr(amt_pkg::IDX_MASK, 32'h1 << b);
      alarm_event <= 6'h1 << b;
      @(posedge pclk);
      alarm_event <= 6'h0;
      rd(amt_pkg::IDX_SUMMARY);
      chk("summary gated", v, 32'h0);
      wr(amt_pkg::IDX_MASK, 32'h0);
      rd(amt_pkg::IDX_SUMMARY);
      chk("summary open", v, 32'h1);
      wr(amt_pkg::IDX_STATUS, 32'h1 << b);
      rd(amt_pkg::IDX_STATUS);
      chk("status cleared", v, 32'h0);
    end
    // summary routed to the pin, then the normal source again
    wr(amt_pkg::IDX_CTRL, 32'h9);
    alarm_event <= 6'h02;
    @(posedge pclk);
    alarm_event <= 6'h0;
    repeat (3) @(posedge pclk);
    chk("pin alarm", {31'h0, calibration_status_pin}, 32'h1);
    wr(amt_pkg::IDX_STATUS, 32'h02);
    cal_status_in <= 1'b1;
    wr(amt_pkg::IDX_CTRL, 32'h1);
    // the pin register picks up the new select one edge after the write lands
    @(posedge pclk);
    chk("pin normal", {31'h0, calibration_status_pin}, 32'h1);
    // trim applied per mode; a value only counts while its valid is up
    for (int m = 0; m < 4; m++) begin
      wr(amt_pkg::IDX_CTRL, {28'h0, md[m]});
      @(posedge pclk);
      chk($sformatf("trims mode %0d", m), {14'h0, core_a_trim_valid, ex[m][17] ? core_a_trim : 8'h0,
        core_b_trim_valid, ex[m][8] ? core_b_trim : 8'h0}, {14'h0, ex[m]});
    end
    // refused accesses: hole in the map and a misaligned address
    rd(10'h2c3);
    chk("unmapped data", v, 32'h0);
    chk("unmapped err", {31'h0, er}, 32'h1);
    apb(1'b0, 12'hb09, 32'h0);
    chk("misaligned err", {31'h0, er}, 32'h1);
    // reset in mid-run restores defaults
    wr(amt_pkg::IDX_MASK, 32'h0);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(amt_pkg::IDX_MASK);
    chk("mask after reset", v, 32'h3f);
    rd(amt_pkg::IDX_LANE);
    chk("lanes after reset", v, 32'hffff);
    final_report;
  end
endmodule // tb
